// File: core/trigger_interface_unit.sv
/*
  one trigger interface unit: eight hardwired trigger inputs, four channels to and from the
  channel matrix, per-connection enables set over a memory-mapped slave with waitrequest,
  acknowledge-held or pulsed trigger outputs, sticky event status with a level interrupt.
  assumes all inputs synchronous to sys_clk; channel matrix combines channels by OR outside.
*/
// Local design decisions: the register addresses and the Avalon-MM register port.
// Functional notes
// - the unit has eight trigger inputs that are fixed wires, not run-time selections.
// - four channels both leave the unit toward the matrix and come back into it.
// - software changes through registers which channels each input and output uses.
// - each input-to-channel and channel-to-output connection has its own enable bit.
// - events combine by channel, so one or many inputs may reach one or many outputs.
// - input 0 on channel 3 reaches every output enabled from channel 3, here or elsewhere.
// - outputs 4 and 5 of the main unit drive the trace macrocell event inputs.
// - output 1 of the second CPU's unit drives that CPU's external debug request.
// - output 2 of the main unit asks the trace port to flush.
// - input acknowledges are not wired; only outputs 3 and 2 take acknowledges.
`timescale 1ns/100ps
`include "xtrig_map.svh"
`default_nettype none
module trigger_interface_unit #(
  parameter int TRIG_N = `XT_TRIG_N,
  parameter int CHAN_N = `XT_CHAN_N,
  parameter logic [`XT_TRIG_N-1:0] ACK_WIRED = 8'h0C
) (
  input wire logic sysClk,
  input wire logic nrst,
  input wire logic [`XT_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [TRIG_N-1:0] trigIn,
  input wire logic [TRIG_N-1:0] trigOutAck,
  output logic [TRIG_N-1:0] trigOut,
  output logic [CHAN_N-1:0] chanOut,
  input wire logic [CHAN_N-1:0] chanIn,
  output logic irq
);
  xtrig_pkg::bus_state_type busState;
  logic ctrlEnable_reg;
  logic [`XT_SEL_W-1:0] sel_reg;
  logic [CHAN_N-1:0] inEn_reg [TRIG_N];
  logic [CHAN_N-1:0] outEn_reg [TRIG_N];
  logic [CHAN_N-1:0] appSet_reg;
  logic [TRIG_N-1:0] status_reg;
  logic [TRIG_N-1:0] mask_reg;
  logic [TRIG_N-1:0] trigInPrev_reg;
  logic [TRIG_N-1:0] trigInRise;
  logic [CHAN_N-1:0] chanEvent;
  logic [TRIG_N-1:0] outFire;
  logic [CHAN_N-1:0] chanNext;
  logic wrTake;
  logic rdTake;

  // one wait state: request taken in BUS_IDLE, answered at the following edge
  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      busState <= xtrig_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (busState)
        xtrig_pkg::BUS_IDLE: begin
          if ((read || write) && waitrequest) begin
            busState <= xtrig_pkg::BUS_ACK;
            waitrequest <= 1'b0;
          end else begin
            waitrequest <= 1'b1;
          end
        end
        xtrig_pkg::BUS_ACK: begin
          busState <= xtrig_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          busState <= xtrig_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign wrTake = write && !waitrequest;
  assign rdTake = read && !waitrequest;

  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      ctrlEnable_reg <= 1'b0;
      sel_reg <= '0;
      mask_reg <= '0;
      appSet_reg <= '0;
    end else begin
      appSet_reg <= '0;
      if (wrTake) begin
        case (address)
          `XT_OFS_CTRL: ctrlEnable_reg <= writedata[`XT_CTRL_GLBEN_BIT];
          `XT_OFS_MASK: mask_reg <= writedata[TRIG_N-1:0];
          `XT_OFS_SEL: sel_reg <= writedata[`XT_SEL_W-1:0];
          `XT_OFS_APPSET: appSet_reg <= writedata[CHAN_N-1:0];
          default: ;
        endcase
      end
    end
  end

  // per-trigger connection enables, written through the selected index
  genvar g;
  generate
    for (g = 0; g < TRIG_N; g++) begin : gen_trig
      always_ff @(posedge sysClk or negedge nrst) begin
        if (!nrst) begin
          inEn_reg[g] <= '0;
          outEn_reg[g] <= '0;
        end else if (wrTake && (sel_reg == `XT_SEL_W'(g))) begin
          if (address == `XT_OFS_IN_EN) begin
            inEn_reg[g] <= writedata[CHAN_N-1:0];
          end
          if (address == `XT_OFS_OUT_EN) begin
            outEn_reg[g] <= writedata[CHAN_N-1:0];
          end
        end
      end
      // an output fires on any enabled channel carrying an event
      assign outFire[g] = ctrlEnable_reg && |(chanIn & outEn_reg[g]);
    end
  endgenerate

  // inputs are edge-detected so a held level counts once
  assign trigInRise = trigIn & ~trigInPrev_reg;

  always_comb begin
    chanNext = appSet_reg;
    for (int i = 0; i < TRIG_N; i++) begin
      if (trigInRise[i]) begin
        chanNext = chanNext | inEn_reg[i];
      end
    end
    chanEvent = ctrlEnable_reg ? chanNext : '0;
  end

  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      trigInPrev_reg <= '0;
      chanOut <= '0;
    end else begin
      trigInPrev_reg <= trigIn;
      chanOut <= chanEvent; // one-cycle channel event out to the matrix
    end
  end

  // acknowledged outputs hold until ack; others pulse for one cycle
  generate
    for (g = 0; g < TRIG_N; g++) begin : gen_out
      always_ff @(posedge sysClk or negedge nrst) begin
        if (!nrst) begin
          trigOut[g] <= 1'b0;
        end else if (ACK_WIRED[g]) begin
          if (outFire[g]) begin
            trigOut[g] <= 1'b1; // new event wins over a returning ack
          end else if (trigOutAck[g]) begin
            trigOut[g] <= 1'b0;
          end
        end else begin
          trigOut[g] <= outFire[g];
        end
      end
    end
  endgenerate

  // sticky input events, cleared by a read of the status word; set wins
  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (rdTake && address == `XT_OFS_STATUS) begin
        // clear only what the read reported, so an event landing meanwhile survives
        status_reg <= (status_reg & ~readdata[TRIG_N-1:0]) | trigInRise;
      end else begin
        status_reg <= status_reg | trigInRise;
      end
      irq <= |(status_reg & mask_reg);
    end
  end

  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      readdata <= `XT_RST_ZERO;
    end else if (read && waitrequest && busState == xtrig_pkg::BUS_IDLE) begin
      case (address)
        `XT_OFS_CTRL: readdata <= {31'h0000_0000, ctrlEnable_reg};
        `XT_OFS_STATUS: readdata <= {{(32-TRIG_N){1'b0}}, status_reg};
        `XT_OFS_MASK: readdata <= {{(32-TRIG_N){1'b0}}, mask_reg};
        `XT_OFS_CHAN: readdata <= {{(32-CHAN_N){1'b0}}, chanIn};
        `XT_OFS_IN_EN: readdata <= {{(32-CHAN_N){1'b0}}, inEn_reg[sel_reg]};
        `XT_OFS_OUT_EN: readdata <= {{(32-CHAN_N){1'b0}}, outEn_reg[sel_reg]};
        `XT_OFS_SEL: readdata <= {{(32-`XT_SEL_W){1'b0}}, sel_reg};
        `XT_OFS_OUTSTATE: readdata <= {{(32-TRIG_N){1'b0}}, trigOut};
        default: readdata <= `XT_RST_ZERO;
      endcase
    end
  end

  // checks
  sequence inRise_s(int i);
    trigInRise[i] && ctrlEnable_reg && inEn_reg[i][0];
  endsequence

  chan_fanout_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (trigInRise[0] && ctrlEnable_reg && inEn_reg[0][3]) |=> chanOut[3])
    else $error("input 0 event did not reach channel 3");
  chan_gate_a: assert property (@(posedge sysClk) disable iff (!nrst)
    !ctrlEnable_reg && !$past(ctrlEnable_reg) |-> chanOut == '0)
    else $error("channel event while disabled");
  chan_combine_a: assert property (@(posedge sysClk) disable iff (!nrst)
    inRise_s(1) or inRise_s(0) |=> chanOut[0])
    else $error("channel 0 lost a combined event");
  chan_out_a: assert property (@(posedge sysClk) disable iff (!nrst)
    $past(chanEvent) == chanOut)
    else $error("channel output mismatch");
  pulse_out_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (outFire[4] && !ACK_WIRED[4]) ##1 !outFire[4] |=> !trigOut[4])
    else $error("unacked output held beyond one cycle");
  fire_out_a: assert property (@(posedge sysClk) disable iff (!nrst)
    outFire[1] |=> trigOut[1])
    else $error("output 1 did not fire");
  hold_ack_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (trigOut[2] && ACK_WIRED[2] && !trigOutAck[2]) |=> trigOut[2])
    else $error("acked output dropped early");
  route_cfg_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (wrTake && address == `XT_OFS_IN_EN && sel_reg == 3'h0)
      |=> inEn_reg[0] == $past(writedata[CHAN_N-1:0]))
    else $error("input enable write not stored");
  irq_level_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (|(status_reg & mask_reg)) |=> irq)
    else $error("interrupt missing for unmasked event");
  bus_answer_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (read || write) && waitrequest && busState == xtrig_pkg::BUS_IDLE |=> !waitrequest)
    else $error("bus did not answer in one cycle");

  // further checks on the bus, the configuration store, the status, the interrupt and the routing
  sequence heldIn_s;
    trigIn[0] ##1 trigIn[0];
  endsequence

  sequence chanRoute_s;
    chanIn[3] && ctrlEnable_reg && outEn_reg[3][3] && outEn_reg[7][3];
  endsequence

  // the answer stands for exactly one cycle
  wait_one_a: assert property (@(posedge sysClk) disable iff (!nrst)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // an answer only ever comes from the answer state
  wait_state_a: assert property (@(posedge sysClk) disable iff (!nrst)
    !waitrequest |-> busState == xtrig_pkg::BUS_ACK)
    else $error("answer outside the answer state");

  // idle keeps the master waiting until a request is seen
  idle_wait_a: assert property (@(posedge sysClk) disable iff (!nrst)
    busState == xtrig_pkg::BUS_IDLE |-> waitrequest)
    else $error("idle state without waitrequest");

  // global enable is stored from the written word
  ctrl_store_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (wrTake && address == `XT_OFS_CTRL) |=> ctrlEnable_reg == $past(writedata[`XT_CTRL_GLBEN_BIT]))
    else $error("control write not stored");

  // interrupt mask is stored from the written word
  mask_store_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (wrTake && address == `XT_OFS_MASK) |=> mask_reg == $past(writedata[TRIG_N-1:0]))
    else $error("mask write not stored");

  // the index that picks which connection word is written
  sel_store_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (wrTake && address == `XT_OFS_SEL) |=> sel_reg == $past(writedata[`XT_SEL_W-1:0]))
    else $error("select write not stored");

  // output enables reach the selected output only
  out_cfg_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (wrTake && address == `XT_OFS_OUT_EN && sel_reg == 3'h3)
      |=> outEn_reg[3] == $past(writedata[CHAN_N-1:0]))
    else $error("output enable write not stored");

  // input enables reach the selected input only
  in_cfg_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (wrTake && address == `XT_OFS_IN_EN && sel_reg == 3'h1)
      |=> inEn_reg[1] == $past(writedata[CHAN_N-1:0]))
    else $error("input 1 enable write not stored");

  // holes in the map read as zero
  rd_unmapped_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (read && waitrequest && busState == xtrig_pkg::BUS_IDLE && address == 4'hF)
      |=> readdata == `XT_RST_ZERO)
    else $error("unmapped read not zero");

  // every input edge is recorded
  status_set_a: assert property (@(posedge sysClk) disable iff (!nrst)
    trigInRise[0] |=> status_reg[0])
    else $error("input event not recorded");

  // a read clears exactly the bits that it reported
  status_clear_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (rdTake && address == `XT_OFS_STATUS && trigInRise == '0)
      |=> (status_reg & $past(readdata[TRIG_N-1:0])) == '0)
    else $error("status not cleared by read");

  // no interrupt without an unmasked event
  irq_low_a: assert property (@(posedge sysClk) disable iff (!nrst)
    !(|(status_reg & mask_reg)) |=> !irq)
    else $error("interrupt without unmasked event");

  // a held input level counts only once
  held_once_a: assert property (@(posedge sysClk) disable iff (!nrst)
    heldIn_s |-> !trigInRise[0])
    else $error("held input counted twice");

  // software pulses land on their channel
  appset_chan_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (appSet_reg[0] && ctrlEnable_reg) |=> chanOut[0])
    else $error("software channel pulse lost");

  // no channel event without a source
  in_gate_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (trigInRise == '0 && appSet_reg == '0) |=> chanOut == '0)
    else $error("channel event without a source");

  // channel events only while the unit is enabled
  chan_mask_a: assert property (@(posedge sysClk) disable iff (!nrst)
    chanOut != '0 |-> $past(ctrlEnable_reg))
    else $error("channel event from a disabled unit");

  // pulsed outputs stay quiet while the unit is off
  out_low_a: assert property (@(posedge sysClk) disable iff (!nrst)
    !ctrlEnable_reg |=> !trigOut[7])
    else $error("output fired while disabled");

  // the flush request drops once acknowledged
  flush_release_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (ACK_WIRED[2] && trigOut[2] && trigOutAck[2] && !outFire[2]) |=> !trigOut[2])
    else $error("flush request held after ack");

  // trace macrocell events fire the cycle after the channel arrives
  msg_pulse_a: assert property (@(posedge sysClk) disable iff (!nrst)
    (outFire[5] && !ACK_WIRED[5]) |=> trigOut[5])
    else $error("trace event output did not fire");

  // one channel fans out to both outputs enabled from it
  fan_route_a: assert property (@(posedge sysClk) disable iff (!nrst)
    chanRoute_s |=> trigOut[3] && trigOut[7])
    else $error("channel 3 did not reach both outputs");
endmodule // trigger_interface_unit
`default_nettype wire

// File: core/xtrig_map.svh
/*
  register offsets, field widths and reset values of the cross-trigger routing block.
  assumes a 32-bit word-addressed slave port; included by bare name.
*/
`ifndef XTRIG_MAP_SVH
`define XTRIG_MAP_SVH
`define XT_ADDR_W 4
`define XT_TRIG_N 8
`define XT_CHAN_N 4
// word offsets (byte address = 4 * offset)
`define XT_OFS_CTRL 4'h0
`define XT_OFS_IN_EN_BASE 4'h1
`define XT_OFS_OUT_EN_BASE 4'h9
`define XT_OFS_STATUS 4'h1
`define XT_OFS_MASK 4'h2
`define XT_OFS_CHAN 4'h3
// second page selected by address bit 3 clear and ctrl-window; kept flat below
`define XT_OFS_IN_EN 4'h4
`define XT_OFS_OUT_EN 4'h5
`define XT_OFS_SEL 4'h6
`define XT_OFS_APPSET 4'h7
`define XT_OFS_OUTSTATE 4'h8
`define XT_CTRL_GLBEN_BIT 0
`define XT_RST_ZERO 32'h0000_0000
`define XT_SEL_W 3
`endif

// File: core/xtrig_pkg.sv
/*
  types for the cross-trigger routing block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package xtrig_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_type;
endpackage

// File: tb/channel_matrix_model.sv
/*
  far-side model of one trigger unit: a channel matrix holding a single unit, plus the trace
  port acknowledge returns on trigger outputs 3 and 2.
  assumes the unit's outputs are registered on sysClk and nrst is the shared debug reset.
*/
`timescale 1ns/100ps
`default_nettype none
module channel_matrix_model #(
  parameter int ACK_DELAY = 2
) (
  input wire logic sysClk,
  input wire logic nrst,
  input wire logic [3:0] chanOut,
  input wire logic [7:0] trigOut,
  output logic [3:0] chanIn,
  output logic [7:0] trigOutAck
);
  logic [1:0] ackReg;
  int waitCnt [2];
  // one unit on the matrix: each channel comes straight back in the same cycle
  assign chanIn = chanOut;
  // only the flush and trigger outputs of the trace port answer; the rest stay tied low
  assign trigOutAck = {4'h0, ackReg, 2'h0};
  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      ackReg <= 2'h0;
      waitCnt <= '{0, 0};
    end else begin
      for (int k = 0; k < 2; k++) begin
        // ack drops once the output is released, so a stale ack never stands
        if (trigOut[k+2] !== 1'b1) begin
          ackReg[k] <= 1'b0;
          waitCnt[k] <= 0;
        end else if (waitCnt[k] == ACK_DELAY) begin
          ackReg[k] <= 1'b1;
        end else begin
          waitCnt[k] <= waitCnt[k] + 1;
        end
      end
    end
  end
endmodule // channel_matrix_model
`default_nettype wire

// File: tb/test_cross_trigger_routing.sv
/*
  self-checking bench for one trigger interface unit: register access, routing, acks, irq.
  assumes the unit's register map header and the channel matrix model beside it.
*/
`timescale 1ns/100ps
`include "xtrig_map.svh"
`default_nettype none
module test_cross_trigger_routing;
  logic sysClk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic busRead = 1'b0;
  logic busWrite = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rdata;
  logic waitrequest, irq;
  logic [7:0] trigIn = 8'h00;
  logic [7:0] trigOutAck, trigOut, outSeen;
  logic [3:0] chanOut, chanIn, chanSeen;
  int err_count = 0;
  int tests_run = 0;
  int holdCnt [8];
  logic [3:0] fabChan [3] = '{4'h4, 4'h2, 4'h1};
  logic [7:0] fabOut [3] = '{8'h02, 8'h30, 8'h04};
  logic [3:0] outSel [4] = '{4'h1, 4'h2, 4'h4, 4'h5};
  logic [31:0] outEn [4] = '{32'h4, 32'h1, 32'h2, 32'h2};
  always #20 sysClk = ~sysClk;
  trigger_interface_unit dut (.sysClk(sysClk), .nrst(nrst), .address(address), .read(busRead),
    .write(busWrite), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .trigIn(trigIn), .trigOutAck(trigOutAck), .trigOut(trigOut), .chanOut(chanOut),
    .chanIn(chanIn), .irq(irq));
  channel_matrix_model #(.ACK_DELAY(2)) partner (.sysClk(sysClk), .nrst(nrst),
    .chanOut(chanOut), .trigOut(trigOut), .chanIn(chanIn), .trigOutAck(trigOutAck));
  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request held until the edge that samples waitrequest low; data taken at that edge
  // the word address is the register offset a debugger adds to the bases
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sysClk);
    busRead <= !w;
    busWrite <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge sysClk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rdata = readdata;
    busRead <= 1'b0;
    busWrite <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h0);
    check(name, rdata, exp);
  endtask
  // one-cycle input pulse, then eight cycles of watching the channels and outputs
  task automatic watch();
    outSeen = 8'h00;
    chanSeen = 4'h0;
    holdCnt = '{default: 0};
    repeat (8) begin
      @(posedge sysClk);
      trigIn <= 8'h00;
      #1;
      outSeen |= trigOut;
      chanSeen |= chanOut;
      for (int b = 0; b < 8; b++) if (trigOut[b] === 1'b1) holdCnt[b]++;
    end
  endtask
  task automatic fire(input int i);
    @(posedge sysClk);
    trigIn[i] <= 1'b1;
    watch();
  endtask
  initial begin
    repeat (3) @(posedge sysClk);
    check("trigOut in reset", trigOut, 32'h0);
    nrst <= 1'b1;
    rdchk(`XT_OFS_CTRL, 32'h0, "ctrl reset");
    rdchk(4'hF, 32'h0, "unmapped read");
    wr(`XT_OFS_SEL, 32'h0);
    wr(`XT_OFS_IN_EN, 32'h8);
    fire(0);
    check("chanOut while off", chanSeen, 32'h0);
    wr(`XT_OFS_CTRL, 32'h1);
    wr(`XT_OFS_SEL, 32'h3);
    wr(`XT_OFS_OUT_EN, 32'h8);
    wr(`XT_OFS_SEL, 32'h7);
    wr(`XT_OFS_OUT_EN, 32'h8);
    wr(`XT_OFS_SEL, 32'h0);
    rdchk(`XT_OFS_IN_EN, 32'h8, "input 0 enables");
    fire(0);
    check("chanOut", chanSeen, 32'h8);
    check("trigOut fan-out", outSeen, 32'h88);
    check("pulse out7", holdCnt[7], 32'h1);
    check("held out3", holdCnt[3] > 1, 32'h1);
    check("out3 released", trigOut, 32'h0);
    xfer(1'b0, `XT_OFS_STATUS, 32'h0);
    wr(`XT_OFS_MASK, 32'h1);
    fire(1);
    check("unrouted input", chanSeen, 32'h0);
    check("irq masked", irq, 32'h0);
    fire(0);
    check("irq raised", irq, 32'h1);
    rdchk(`XT_OFS_STATUS, 32'h3, "status sticky");
    repeat (3) @(posedge sysClk);
    #1 check("irq cleared", irq, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(`XT_OFS_SEL, {28'h0, outSel[k]});
      wr(`XT_OFS_OUT_EN, outEn[k]);
    end
    // fabric breakpoint, message and flush inputs each on their own channel
    for (int k = 0; k < 3; k++) begin
      wr(`XT_OFS_SEL, k + 1);
      wr(`XT_OFS_IN_EN, {28'h0, fabChan[k]});
      fire(k + 1);
      check("fabric chan", chanSeen, fabChan[k]);
      check("fabric out", outSeen, fabOut[k]);
    end
    wr(`XT_OFS_SEL, 32'h0);
    wr(`XT_OFS_IN_EN, 32'h9);
    fire(0);
    check("one to many", outSeen, 32'h8C);
    wr(`XT_OFS_APPSET, 32'h1);
    watch();
    check("appset chan", chanSeen, 32'h1);
    check("appset out", outSeen, 32'h04);
    rdchk(`XT_OFS_OUTSTATE, 32'h0, "outputs idle");
    print_verdict();
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule // test_cross_trigger_routing
`default_nettype wire
